// ---- src/asp_serial_port.sv ----
/*
 * async serial port: register port, transmitter with holding buffer, oversampled receiver.
 * assumes one 200 MHz clock, synchronous reset, and a master that never waits.
 */
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "asp_map.svh"

module asp_serial_port
    import asp_pkg::*;
#(
    parameter int DIV_W = 16
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    // register port
    input  wire asp_bus_s         bus_i,
    output logic      [7:0]       rdata_o,
    // core interrupt mask
    input  wire logic             core_irq_mask_i,
    output logic                  irq_o,
    // wakeup
    output logic                  addr_mark_o,
    // serial pins
    input  wire logic             serial_rx_pin_i,
    output logic                  tx_o,
    output logic                  tx_oe_o
);

    initial begin
        if (DIV_W < 4 || DIV_W > 16) begin
            $error("asp_serial_port: DIV_W out of range");
        end
    end

    // ****************************
    // helpers
    // ****************************
    function automatic logic par_of(input logic [8:0] w, input logic m, input logic odd);
        logic p;
        p = m ? ^w[7:0] : ^w[6:0];
        return p ^ odd;
    endfunction

    function automatic logic [3:0] nbits(input logic m, input logic parity_enable);
        return (m ? 4'h9 : 4'h8);
    endfunction

    // ****************************
    // registers
    // ****************************
    logic [7:0] ctrl1_q;
    logic [7:0] ctrl2_q;
    logic [DIV_W-1:0] baud_tx_q;
    logic [DIV_W-1:0] baud_rx_q;
    logic       tx_buffer_empty_q, tc_q, rdrf_q, or_q, nf_q, pe_q;
    logic       st_armed_q;
    logic [8:0] rx_word_q;
    logic       m_b, pce_b, ps_b, te_b, re_b;

    assign m_b   = ctrl1_q[`ASP_C1_M];
    assign pce_b = ctrl1_q[`ASP_C1_PCE];
    assign ps_b  = ctrl1_q[`ASP_C1_PS];
    assign te_b  = ctrl2_q[`ASP_C2_TE];
    assign re_b  = ctrl2_q[`ASP_C2_RE];

    logic wr_data, rd_status, rd_data, clr_seq;
    assign wr_data   = bus_i.wr && bus_i.addr == `ASP_OFS_DATA;
    assign rd_status = bus_i.rd && bus_i.addr == `ASP_OFS_STATUS;
    assign rd_data   = bus_i.rd && bus_i.addr == `ASP_OFS_DATA;
    assign clr_seq   = wr_data && st_armed_q;

    // tx and rx events from the shifters
    logic tx_load_ev, tx_done_ev, brk_take;
    logic rx_done_ev, rx_par_bad, rx_noise;
    logic [8:0] rx_shift_q;

    // ****************************
    // control registers
    // ****************************
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl1_q   <= 8'h00;
            ctrl2_q   <= 8'h00;
            baud_tx_q <= DIV_W'(`ASP_RST_BAUD);
            baud_rx_q <= DIV_W'(`ASP_RST_BAUD);
        end else begin
            if (bus_i.wr && bus_i.addr == `ASP_OFS_CTRL1) begin
                ctrl1_q <= {ctrl1_q[7], bus_i.wdata[6:0]};
            end
            if (bus_i.wr && bus_i.addr == `ASP_OFS_CTRL2) begin
                ctrl2_q <= bus_i.wdata;
            end else if (brk_take) begin
                ctrl2_q[`ASP_C2_SBK] <= 1'b0;
            end
            // independent tx and rx divisors
            if (bus_i.wr && bus_i.addr == `ASP_OFS_BAUD_TX) begin
                baud_tx_q <= DIV_W'(bus_i.wdata);
            end
            if (bus_i.wr && bus_i.addr == `ASP_OFS_BAUD_RX) begin
                baud_rx_q <= DIV_W'(bus_i.wdata);
            end
            if (rx_done_ev) begin
                ctrl1_q[`ASP_C1_R8] <= rx_shift_q[8];
            end
        end
    end

    // ****************************
    // status flags
    // ****************************
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_armed_q <= 1'b0;
            tx_buffer_empty_q     <= 1'b1;
            tc_q       <= 1'b1;
        end else begin
            if (rd_status) begin
                st_armed_q <= 1'b1;
            end else if (wr_data) begin
                st_armed_q <= 1'b0;
            end
            // set wins over the clear sequence
            if (tx_load_ev) begin
                tx_buffer_empty_q <= 1'b1;
            end else if (clr_seq) begin
                tx_buffer_empty_q <= 1'b0;
            end
            if (tx_done_ev) begin
                tc_q <= 1'b1;
            end else if (clr_seq) begin
                tc_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdrf_q    <= 1'b0;
            or_q      <= 1'b0;
            nf_q      <= 1'b0;
            pe_q      <= 1'b0;
            rx_word_q <= 9'h000;
        end else begin
            if (rx_done_ev && rdrf_q && !rd_data) begin
                or_q <= 1'b1;
            end else if (rd_data) begin
                or_q <= 1'b0;
            end
            if (rx_done_ev && !(rdrf_q && !rd_data)) begin
                rdrf_q    <= 1'b1;
                rx_word_q <= rx_shift_q;
            end else if (rd_data) begin
                rdrf_q <= 1'b0;
            end
            if (rx_done_ev && rx_noise) begin
                nf_q <= 1'b1;
            end else if (rd_data) begin
                nf_q <= 1'b0;
            end
            if (rx_done_ev && rx_par_bad) begin
                pe_q <= 1'b1;
            end else if (rd_data) begin
                pe_q <= 1'b0;
            end
        end
    end

    // ****************************
    // read port and interrupt
    // ****************************
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= 8'h00;
            irq_o   <= 1'b0;
        end else begin
            rdata_o <= 8'h00;
            if (bus_i.rd) begin
                case (bus_i.addr)
                    `ASP_OFS_STATUS:  rdata_o <= {tx_buffer_empty_q, tc_q, rdrf_q, 1'b0, or_q, nf_q, 1'b0, pe_q};
                    `ASP_OFS_DATA:    rdata_o <= rx_word_q[7:0];
                    `ASP_OFS_BAUD_TX: rdata_o <= baud_tx_q[7:0];
                    `ASP_OFS_BAUD_RX: rdata_o <= baud_rx_q[7:0];
                    `ASP_OFS_CTRL1:   rdata_o <= ctrl1_q;
                    `ASP_OFS_CTRL2:   rdata_o <= ctrl2_q;
                    default:          rdata_o <= 8'h00;
                endcase
            end
            irq_o <= !core_irq_mask_i &&
                     ((tx_buffer_empty_q && ctrl2_q[`ASP_C2_TIE]) ||
                      (tc_q && ctrl2_q[`ASP_C2_TX_DONE_IRQ_EN]) ||
                      (pe_q && ctrl1_q[`ASP_C1_PIE]));
        end
    end

    // ****************************
    // transmitter
    // ****************************
    asp_tx_e    tx_st_q;
    logic [DIV_W+3:0] tx_cnt_q;
    logic [3:0] tx_bit_q;
    logic [10:0] tx_frame_q;
    logic [3:0] tx_len_q;
    logic [8:0] hold_q;
    logic       hold_full_q;
    logic       te_prev_q;
    logic       tx_tick;
    logic [8:0] wr_word;

    // divider floor of one sample period keeps zero divisor from stalling
    assign tx_tick = tx_cnt_q == {baud_tx_q, 4'hf};
    assign wr_word = pce_b ? (m_b ? {par_of({1'b0, bus_i.wdata}, 1'b1, ps_b), bus_i.wdata}
                                  : {1'b0, par_of({1'b0, bus_i.wdata}, 1'b0, ps_b), bus_i.wdata[6:0]})
                           : {ctrl1_q[`ASP_C1_T8], bus_i.wdata};
    assign brk_take  = tx_st_q == ASP_TX_IDLE && !hold_full_q && ctrl2_q[`ASP_C2_SBK];
    assign tx_load_ev = tx_st_q == ASP_TX_IDLE && (hold_full_q || (wr_data && !brk_take));
    assign tx_done_ev = tx_st_q == ASP_TX_SHIFT && tx_tick && tx_bit_q == tx_len_q;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_st_q     <= ASP_TX_OFF;
            tx_cnt_q    <= '0;
            tx_bit_q    <= 4'h0;
            tx_frame_q  <= 11'h7ff;
            tx_len_q    <= 4'h0;
            hold_q      <= 9'h000;
            hold_full_q <= 1'b0;
            te_prev_q   <= 1'b0;
        end else begin
            te_prev_q <= te_b;
            if (wr_data && (tx_st_q != ASP_TX_IDLE || hold_full_q)) begin
                hold_q      <= wr_word;
                hold_full_q <= 1'b1;
            end else if (tx_load_ev) begin
                hold_full_q <= 1'b0;
            end
            case (tx_st_q)
                ASP_TX_OFF: begin
                    if (te_b && !te_prev_q) begin
                        // idle preamble: all ones for a whole frame
                        tx_frame_q <= 11'h7ff;
                        tx_len_q   <= nbits(m_b, pce_b) + 4'h1;
                        tx_bit_q   <= 4'h0;
                        tx_cnt_q   <= '0;
                        tx_st_q    <= ASP_TX_SHIFT;
                    end
                end
                ASP_TX_IDLE: begin
                    tx_cnt_q <= '0;
                    tx_bit_q <= 4'h0;
                    tx_len_q <= nbits(m_b, pce_b) + 4'h1;
                    if (!te_b) begin
                        tx_st_q <= ASP_TX_OFF;
                    end else if (hold_full_q) begin
                        tx_frame_q <= {1'b1, hold_q[8] | !m_b, hold_q[7:0], 1'b0};
                        tx_st_q    <= ASP_TX_SHIFT;
                    end else if (brk_take) begin
                        // low through start and data, stop bit high
                        tx_frame_q <= m_b ? 11'h400 : 11'h600;
                        tx_st_q    <= ASP_TX_SHIFT;
                    end else if (wr_data) begin
                        tx_frame_q <= {1'b1, wr_word[8] | !m_b, wr_word[7:0], 1'b0};
                        tx_st_q    <= ASP_TX_SHIFT;
                    end
                end
                ASP_TX_SHIFT: begin
                    tx_cnt_q <= tx_tick ? '0 : tx_cnt_q + 1'b1;
                    if (tx_tick) begin
                        tx_frame_q <= {1'b1, tx_frame_q[10:1]};
                        tx_bit_q   <= tx_bit_q + 4'h1;
                        if (tx_done_ev) begin
                            tx_st_q <= ASP_TX_IDLE;
                        end
                    end
                end
                default: tx_st_q <= ASP_TX_OFF;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_o    <= 1'b1;
            tx_oe_o <= 1'b0;
        end else begin
            tx_oe_o <= te_b || re_b;
            tx_o    <= (tx_st_q == ASP_TX_SHIFT) ? tx_frame_q[0] : 1'b1;
        end
    end

    // ****************************
    // receiver
    // ****************************
    logic       rx_s1_q, rx_s2_q;
    asp_rx_e    rx_st_q;
    logic [DIV_W-1:0] rx_div_q;
    logic [3:0] rx_smp_q;
    logic [3:0] rx_bit_q;
    logic [2:0] vote_q;
    logic       noise_q;
    logic       rx_tick, maj;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end else begin
            rx_s1_q <= serial_rx_pin_i;
            rx_s2_q <= rx_s1_q;
        end
    end

    assign rx_tick = rx_div_q == baud_rx_q;
    assign maj = (vote_q[0] & vote_q[1]) | (vote_q[1] & vote_q[2]) | (vote_q[0] & vote_q[2]);
    assign rx_done_ev = rx_st_q == ASP_RX_DATA && rx_tick && rx_smp_q == 4'hf &&
                        rx_bit_q == nbits(m_b, pce_b);
    assign rx_noise   = noise_q;
    assign rx_par_bad = pce_b && (par_of(rx_shift_q, m_b, ps_b) != (m_b ? rx_shift_q[8] : rx_shift_q[7]));

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_st_q    <= ASP_RX_HUNT;
            rx_div_q   <= '0;
            rx_smp_q   <= 4'h0;
            rx_bit_q   <= 4'h0;
            vote_q     <= 3'h7;
            noise_q    <= 1'b0;
            rx_shift_q <= 9'h000;
        end else begin
            rx_div_q <= rx_tick ? '0 : rx_div_q + 1'b1;
            case (rx_st_q)
                ASP_RX_HUNT: begin
                    if (re_b && !rx_s2_q) begin
                        // restart the sample phase on each start edge
                        rx_div_q <= '0;
                        rx_smp_q <= 4'h0;
                        rx_bit_q <= 4'h0;
                        noise_q  <= 1'b0;
                        rx_st_q  <= ASP_RX_START;
                    end
                end
                ASP_RX_START, ASP_RX_DATA: begin
                    if (rx_tick) begin
                        rx_smp_q <= rx_smp_q + 4'h1;
                        if (rx_smp_q >= `ASP_VOTE_FIRST && rx_smp_q <= `ASP_VOTE_LAST) begin
                            vote_q <= {rx_s2_q, vote_q[2:1]};
                        end
                        if (rx_smp_q == 4'hf) begin
                            if (vote_q != 3'h0 && vote_q != 3'h7) begin
                                noise_q <= 1'b1;
                            end
                            if (rx_st_q == ASP_RX_START) begin
                                // false start when the vote says high
                                rx_st_q <= maj ? ASP_RX_HUNT : ASP_RX_DATA;
                            end else if (rx_bit_q == nbits(m_b, pce_b)) begin
                                rx_st_q <= ASP_RX_HUNT;
                            end else begin
                                rx_bit_q <= rx_bit_q + 4'h1;
                                rx_shift_q <= m_b ? {maj, rx_shift_q[8:1]}
                                                  : {1'b0, maj, rx_shift_q[7:1]};
                            end
                        end
                    end
                end
                default: rx_st_q <= ASP_RX_HUNT;
            endcase
        end
    end

    // address mark comes from data msb, never the parity slot
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            addr_mark_o <= 1'b0;
        end else if (rx_done_ev) begin
            addr_mark_o <= pce_b ? (m_b ? rx_shift_q[7] : rx_shift_q[6])
                                 : (m_b ? rx_shift_q[8] : rx_shift_q[7]);
        end
    end

endmodule
`default_nettype wire

// ---- src/asp_map.svh ----
/*
 * register offsets, field positions, reset values and timing counts of the async serial port.
 * assumes a plain strobe register port with 8-bit data and one clock at 200 MHz.
 */
//
// Operation
// - both enables off: tx pin returns to general-purpose port function.
// - any enable on and nothing to send: tx pin held high.
// - frame is idle, start bit, 8 or 9 data bits lsb first, stop bit.
// - word-length set: 9-bit words, ninth bit from tx_ninth_bit.
// - setting tx_enable connects pin and sends one idle frame first.
// - buffer-empty and done flags clear only by status read then data write.
// - write during transmission waits in holding buffer until frame ends.
// - write while idle loads shifter, starts, sets buffer-empty at once.
// - buffer-empty interrupt only when its enable set and core mask clear.
// - after stop bit or break, set done flag, interrupt if enabled and unmasked.
// - send_break loads a break character sized by word length.
// - frame format follows word-length and parity_enable combinations.
// - address-mark wakeup uses data msb, never the parity bit.
// - parity even or odd over 7 or 8 low bits plus parity bit.
// - parity on transmit replaces data msb with generated parity.
// - receive parity failure sets parity_error_flag, interrupt if enabled.
// - each bit sampled 16 times, majority of samples 8, 9, 10.
// - disagreeing voting samples set noise_flag, majority still used.
// - oversampling realigned on every detected start bit.
// - tx and rx baud rates programmable independently up to 250K baud.
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH

// ****************************
// register offsets
// ****************************
`define ASP_OFS_STATUS   4'h0
`define ASP_OFS_DATA     4'h1
`define ASP_OFS_BAUD_TX  4'h2
`define ASP_OFS_BAUD_RX  4'h3
`define ASP_OFS_CTRL1    4'h4
`define ASP_OFS_CTRL2    4'h5

// ****************************
// field positions
// ****************************
`define ASP_ST_TX_BUFFER_EMPTY      7
`define ASP_ST_TC        6
`define ASP_ST_RDRF      5
`define ASP_ST_OR        3
`define ASP_ST_NF        2
`define ASP_ST_PE        0
`define ASP_C1_R8        7
`define ASP_C1_T8        6
`define ASP_C1_M         4
`define ASP_C1_PCE       2
`define ASP_C1_PS        1
`define ASP_C1_PIE       0
`define ASP_C2_TIE       7
`define ASP_C2_TX_DONE_IRQ_EN      6
`define ASP_C2_TE        3
`define ASP_C2_RE        2
`define ASP_C2_SBK       0

// ****************************
// reset values and timing
// ****************************
`define ASP_RST_BAUD     16'h0000
`define ASP_OVERSAMPLE   16
`define ASP_VOTE_FIRST   4'h7
`define ASP_VOTE_LAST    4'h9
`define ASP_CLK_MHZ      200
`define ASP_MAX_BAUD_K   250
`define ASP_MIN_DIV      ((`ASP_CLK_MHZ * 1000) / (`ASP_MAX_BAUD_K * `ASP_OVERSAMPLE))

`endif

// ---- src/asp_pkg.sv ----
/*
 * types of the async serial port.
 * assumes asp_map.svh for the numbers.
 */
package asp_pkg;

    // ****************************
    // register bus carrier
    // ****************************
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } asp_bus_s;

    typedef enum logic [1:0] {
        ASP_TX_OFF   = 2'b00,
        ASP_TX_IDLE  = 2'b01,
        ASP_TX_SHIFT = 2'b10
    } asp_tx_e;

    typedef enum logic [1:0] {
        ASP_RX_HUNT  = 2'b00,
        ASP_RX_START = 2'b01,
        ASP_RX_DATA  = 2'b10
    } asp_rx_e;

endpackage

// ---- dv/asp_far_end.sv ----
/*
 * far-side serial equipment: sends frames into the port and captures frames from it.
 * assumes the bench calls its tasks just after a rising clock edge; bit times are in clocks.
 */
`timescale 1ns/1ps
`default_nettype none

module asp_far_end
    import asp_pkg::*;
(
    // clock
    input  wire logic clk_i,
    // serial lines
    input  wire logic tx_i,
    output var  logic rx_o
);
    // ****************************
    // line drive
    // ****************************
    // idle line stays high between frames; the rule holds the level, not a pull-up
    initial rx_o = 1'b1;

    // exact bit timing, well inside the allowed drift; nz flips the middle of bit 0
    task automatic send(input logic [8:0] w, input int nb, input int bt, input bit nz);
        rx_o <= 1'b0;
        repeat (bt) @(posedge clk_i);
        for (int i = 0; i < nb; i++) begin
            rx_o <= w[i];
            if (nz && i == 0) begin
                repeat (bt / 2) @(posedge clk_i);
                rx_o <= ~w[i];
                repeat (2) @(posedge clk_i);
                rx_o <= w[i];
                repeat (bt / 2 - 2) @(posedge clk_i);
            end else begin
                repeat (bt) @(posedge clk_i);
            end
        end
        rx_o <= 1'b1;
        // extra idle lets the synchroniser and stop vote settle before the bench looks
        repeat (bt + 8) @(posedge clk_i);
    endtask

    // ****************************
    // line capture
    // ****************************
    // samples mid-bit; the wait for a start bit is bounded so a dead line cannot hang
    task automatic recv(input int nb, input int bt, output logic [8:0] w, output logic s);
        int n;
        n = 0;
        w = '0;
        while (tx_i !== 1'b0 && n < 4000) begin
            @(posedge clk_i);
            n++;
        end
        repeat (bt / 2) @(posedge clk_i);
        for (int i = 0; i < nb; i++) begin
            repeat (bt) @(posedge clk_i);
            w[i] = tx_i;
        end
        repeat (bt) @(posedge clk_i);
        s = tx_i;
    endtask
endmodule

`default_nettype wire

// ---- dv/asp_serial_port_sva.sv ----
/*
 * assertions on the async serial port ports.
 * assumes the register map header and a single clock domain with synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "asp_map.svh"

module asp_serial_port_sva
    import asp_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    // register port
    input  wire asp_bus_s   bus_i,
    input  wire logic [7:0] rdata_o,
    // interrupt and pins
    input  wire logic       core_irq_mask_i,
    input  wire logic       irq_o,
    input  wire logic       addr_mark_o,
    input  wire logic       serial_rx_pin_i,
    input  wire logic       tx_o,
    input  wire logic       tx_oe_o
);
    // ****************************
    // shadow of control bits
    // ****************************
    logic       en_q;
    logic       ie_q;
    logic       pie_q;
    logic [1:0] age_q;

    // age counts settled cycles since the last control write, so latency is tolerated
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            en_q  <= 1'b0;
            ie_q  <= 1'b0;
            pie_q <= 1'b0;
            age_q <= 2'h0;
        end else if (bus_i.wr && (bus_i.addr == `ASP_OFS_CTRL2 || bus_i.addr == `ASP_OFS_CTRL1)) begin
            age_q <= 2'h0;
            if (bus_i.addr == `ASP_OFS_CTRL2) begin
                en_q <= bus_i.wdata[3] | bus_i.wdata[2];
                ie_q <= bus_i.wdata[7] | bus_i.wdata[6];
            end else begin
                pie_q <= bus_i.wdata[0];
            end
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    // ****************************
    // sequences
    // ****************************
    sequence s_start_low;
        (!tx_o) [*8];
    endsequence

    sequence s_masked;
        (core_irq_mask_i && !pie_q) [*2];
    endsequence

    // ****************************
    // assertions
    // ****************************
    a_reset_state: assert property (disable iff (1'b0) srst_i |=> tx_o && !tx_oe_o && !irq_o && rdata_o == 8'h00)
        else $error("outputs not at rest after reset");
    a_pin_release: assert property (age_q == 2'h3 |-> tx_oe_o == en_q)
        else $error("pin ownership does not follow the enables");
    a_low_driven: assert property (!tx_o |-> tx_oe_o)
        else $error("line low while the pin is released");
    a_start_len: assert property ($fell(tx_o) |-> s_start_low)
        else $error("start bit shorter than eight clocks");
    a_irq_masked: assert property (s_masked |-> !irq_o)
        else $error("transmit interrupt while core mask set");
    a_irq_disabled: assert property (!ie_q && !pie_q && age_q == 2'h3 |-> !irq_o)
        else $error("interrupt with every enable off");
    a_read_only: assert property (rdata_o != 8'h00 |-> $past(bus_i.rd))
        else $error("read data without a read");
    a_read_zero: assert property (!bus_i.rd |=> rdata_o == 8'h00)
        else $error("read data not cleared");
    a_mark_stop: assert property ($changed(addr_mark_o) |-> serial_rx_pin_i)
        else $error("address mark changed away from stop bit");
endmodule

bind asp_serial_port asp_serial_port_sva asp_serial_port_sva_i (
    .clk_i           (clk_i),
    .srst_i          (srst_i),
    .bus_i           (bus_i),
    .rdata_o         (rdata_o),
    .core_irq_mask_i (core_irq_mask_i),
    .irq_o           (irq_o),
    .addr_mark_o     (addr_mark_o),
    .serial_rx_pin_i (serial_rx_pin_i),
    .tx_o            (tx_o),
    .tx_oe_o         (tx_oe_o)
);

`default_nettype wire

// ---- dv/tb_top.sv ----
/*
 * self-checking bench of the async serial port: register tasks plus a far-side model.
 * assumes a 200 MHz clock; tx divisor 0 (16 clocks a bit), rx divisor 1 (32 clocks a bit).
 */
`timescale 1ns/1ps
`default_nettype none
`include "asp_map.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; $display("wrong value at %0t: got %0h expected %0h", $time, (a), (e)); end end

module tb_top
    import asp_pkg::*;
;
    logic       clk_i, srst_i, core_irq_mask_i, serial_rx_pin_i;
    logic       irq_o, addr_mark_o, tx_o, tx_oe_o, s;
    asp_bus_s   bus;
    logic [7:0] rdata_o, d;
    logic [8:0] w;
    int         n_mismatch, tests_run, cnt;
    logic [7:0] c1 [4] = '{8'h00, 8'h06, 8'h50, 8'h14};
    logic [8:0] ex [4] = '{9'h035, 9'h0b5, 9'h135, 9'h035};

    asp_serial_port #(.DIV_W(16)) asp_serial_port_i (.clk_i(clk_i), .srst_i(srst_i), .bus_i(bus),
        .rdata_o(rdata_o), .core_irq_mask_i(core_irq_mask_i), .irq_o(irq_o), .addr_mark_o(addr_mark_o),
        .serial_rx_pin_i(serial_rx_pin_i), .tx_o(tx_o), .tx_oe_o(tx_oe_o));
    asp_far_end asp_far_end_i (.clk_i(clk_i), .tx_i(tx_o), .rx_o(serial_rx_pin_i));

    // ****************************
    // clock, bus tasks, verdict
    // ****************************
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // an idle cycle after each strobe keeps one assignment per signal per time step
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        bus <= '{a, v, 1'b1, 1'b0};
        @(posedge clk_i);
        bus <= '0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_i);
        bus <= '0;
        #1 v = rdata_o;
        @(posedge clk_i);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk_i);
        n_mismatch++;
        results();
    end

    // ****************************
    // tests
    // ****************************
    initial begin
        srst_i = 1'b1;
        bus = '0;
        core_irq_mask_i = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        repeat (16) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        `CHK(tx_oe_o, 1'b0)
        rd(`ASP_OFS_STATUS, d);
        `CHK(d, 8'hc0)
        rd(4'hf, d);
        `CHK(d, 8'h00)
        wr(`ASP_OFS_BAUD_TX, 8'h00);
        wr(`ASP_OFS_BAUD_RX, 8'h01);
        wr(`ASP_OFS_CTRL2, 8'h0c);
        @(posedge clk_i);
        `CHK({tx_oe_o, tx_o}, 2'b11)
        rd(`ASP_OFS_STATUS, d);
        wr(`ASP_OFS_DATA, 8'h35);
        cnt = 0;
        while (tx_o !== 1'b0 && cnt < 1000) begin
            @(posedge clk_i);
            cnt++;
        end
        `CHK(cnt >= 140, 1'b1)
        asp_far_end_i.recv(8, 16, w, s);
        `CHK(w, 9'h035)
        repeat (16) @(posedge clk_i);
        // every word length and parity combination of the frame table
        for (int k = 0; k < 4; k++) begin
            wr(`ASP_OFS_CTRL1, c1[k]);
            rd(`ASP_OFS_STATUS, d);
            wr(`ASP_OFS_DATA, 8'h35);
            asp_far_end_i.recv(k >= 2 ? 9 : 8, 16, w, s);
            `CHK(w, ex[k])
            repeat (16) @(posedge clk_i);
        end
        wr(`ASP_OFS_CTRL1, 8'h00);
        rd(`ASP_OFS_STATUS, d);
        wr(`ASP_OFS_DATA, 8'h5a);
        rd(`ASP_OFS_STATUS, d);
        `CHK(d[7:6], 2'b10)
        wr(`ASP_OFS_DATA, 8'hc3);
        rd(`ASP_OFS_STATUS, d);
        `CHK(d[7:6], 2'b00)
        asp_far_end_i.recv(8, 16, w, s);
        `CHK(w, 9'h05a)
        asp_far_end_i.recv(8, 16, w, s);
        `CHK(w, 9'h0c3)
        repeat (32) @(posedge clk_i);
        rd(`ASP_OFS_STATUS, d);
        `CHK(d[7:6], 2'b11)
        wr(`ASP_OFS_CTRL2, 8'h8c);
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b1)
        core_irq_mask_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        `CHK(irq_o, 1'b0)
        core_irq_mask_i <= 1'b0;
        wr(`ASP_OFS_CTRL2, 8'h4c);
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b1)
        wr(`ASP_OFS_CTRL2, 8'h0d);
        asp_far_end_i.recv(8, 16, w, s);
        `CHK({s, w}, 10'h200)
        repeat (16) @(posedge clk_i);
        rd(`ASP_OFS_STATUS, d);
        `CHK(d[6], 1'b1)
        // receive side: clean, noisy, bad parity, then overrun
        asp_far_end_i.send(9'h0a5, 8, 32, 1'b0);
        rd(`ASP_OFS_STATUS, d);
        `CHK({d[5], d[2]}, 2'b10)
        rd(`ASP_OFS_DATA, d);
        `CHK(d, 8'ha5)
        `CHK(addr_mark_o, 1'b1)
        asp_far_end_i.send(9'h03c, 8, 32, 1'b1);
        rd(`ASP_OFS_STATUS, d);
        `CHK(d[2], 1'b1)
        rd(`ASP_OFS_DATA, d);
        `CHK(d, 8'h3c)
        wr(`ASP_OFS_CTRL1, 8'h05);
        asp_far_end_i.send(9'h040, 8, 32, 1'b0);
        repeat (4) @(posedge clk_i);
        `CHK(irq_o, 1'b1)
        `CHK(addr_mark_o, 1'b1)
        rd(`ASP_OFS_STATUS, d);
        `CHK(d[0], 1'b1)
        rd(`ASP_OFS_DATA, d);
        wr(`ASP_OFS_CTRL1, 8'h00);
        asp_far_end_i.send(9'h011, 8, 32, 1'b0);
        asp_far_end_i.send(9'h022, 8, 32, 1'b0);
        rd(`ASP_OFS_STATUS, d);
        `CHK(d[3], 1'b1)
        rd(`ASP_OFS_DATA, d);
        `CHK(d, 8'h11)
        results();
    end
endmodule

`default_nettype wire
